// >>> rtl/tcc_core.v
// Behaviour
// - Width select picks 8, 16 or 32 bits; 16 after reset.
// - Period register exists in every width but acts as top only in 8-bit width.
// - 32-bit width joins a pair; the even unit holds all configuration.
// - Follower unit shows follower status; its writes never touch the counter.
// - Up wraps top to zero; down wraps zero to top.
// - Direction bit 0 counts up, 1 down, one step per tick, changeable live.
// - Up wrap from top to zero sets the overflow flag.
// - Overflow or underflow emits an event when its output enable is set.
// - One-shot stops counting after the wrap.
// - Count writes accepted while running and beat count, clear or reload.
// - Start holds zero up or top down unless written or stopped elsewhere.
// - Stop command while running loads start value, clears waves, sets halted.
// - Retrigger restarts count while running, resumes from value while stopped.
// - Retrigger action: enable does not start; each event starts or restarts.
// - Count action: each event steps the counter by direction.
// - Start action: event starts a stopped counter; retrigger command also starts.
// - Channels compare counter against their value from reset on.
// - Match sets the channel flag on the tick edge; event when enabled.
// - Each waveform output has its own invert enable.
// - Mode field picks four modes; normal modes use period or maximum as top.
// - Normal frequency toggles each output on its match and sets the flag.
// - Match frequency uses channel 0 as top; output 0 toggles on update.
// - Count ticks come from events when counting events, else from the prescaler, and drive the counter.
// - Counting events bypasses the prescaler.
// - Update is top while up, zero while down.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.vh"

module tcc_core #(
  parameter PW = 10
) (
  input  wire        CLK_I,
  input  wire        RSTN_I,
  input  wire [7:0]  ADR_I,
  input  wire [31:0] DAT_I,
  input  wire [3:0]  SEL_I,
  input  wire        WE_I,
  input  wire        CYC_I,
  input  wire        STB_I,
  output reg  [31:0] DAT_O,
  output reg         ACK_O,
  input  wire        EVENT_I,
  input  wire        FOLLOWER_I,
  output reg         EV_OVF_O,
  output reg  [1:0]  EV_MATCH_O,
  output reg  [1:0]  WAVE_O
);

  localparam NCH = 2;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [31:0] ctrla_reg;
  reg  [1:0]  ctrlb_reg;
  reg  [31:0] evctrl_reg;
  reg  [1:0]  ctrlc_reg;
  reg  [7:0]  period_reg;
  reg  [31:0] cc_reg [0:NCH-1];
  reg         ovf_flag_reg;
  reg  [1:0]  mc_flag_reg;
  reg  [31:0] cnt_reg;
  reg  [31:0] cnt_next;
  reg         run_reg;
  reg         run_next;
  reg         halt_reg;
  reg         halt_next;
  reg         written_reg;
  reg         en_q_reg;
  reg         wclr;
  reg         tick_step;
  reg  [31:0] rd_data;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = dat[b*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  wire        req     = CYC_I & STB_I;
  wire        wr      = req & WE_I & ACK_O;
  wire        en      = ctrla_reg[`TCC_EN_BIT];
  wire        follow  = FOLLOWER_I;
  wire        wr_ctrla  = wr & (ADR_I == `TCC_ADR_CTRLA);
  wire        wr_ctrlb  = wr & (ADR_I == `TCC_ADR_CTRLB);
  wire        wr_evctrl = wr & (ADR_I == `TCC_ADR_EVCTRL);
  wire        wr_ctrlc  = wr & (ADR_I == `TCC_ADR_CTRLC);
  wire        wr_flag   = wr & (ADR_I == `TCC_ADR_INTFLAG);
  // Follower writes to count, period and channel values are dropped so the joined counter stays intact
  wire        wr_cnt    = wr & ~follow & (ADR_I == `TCC_ADR_COUNT);
  wire        wr_per    = wr & ~follow & (ADR_I == `TCC_ADR_PERIOD);
  wire        wr_chv0   = wr & ~follow & (ADR_I == `TCC_ADR_CHV0);
  wire        wr_chv1   = wr & ~follow & (ADR_I == `TCC_ADR_CHV1);
  wire [31:0] wdat_cnt  = merge(cnt_reg, DAT_I, SEL_I);
  wire [31:0] ctrlb_w   = merge({30'h0, ctrlb_reg}, DAT_I, SEL_I);
  wire [1:0]  cmd       = wr_ctrlb ? ctrlb_w[`TCC_CMD_RNG] : 2'h0;

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ACK_O <= 1'b0;
      DAT_O <= `TCC_ZERO32;
    end else begin
      // Ack drops in the cycle after it was given
      ACK_O <= req & ~ACK_O;
      if (req & ~ACK_O) begin
        DAT_O <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  wire [31:0] ctrla_w  = merge(ctrla_reg, DAT_I, SEL_I) & `TCC_CTRLA_MASK;
  wire [31:0] evctrl_w = merge(evctrl_reg, DAT_I, SEL_I) & `TCC_EVCTRL_MASK;

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrla_reg  <= `TCC_RST_CTRLA;
      ctrlb_reg  <= 2'h0;
      evctrl_reg <= `TCC_ZERO32;
      ctrlc_reg  <= 2'h0;
      period_reg <= `TCC_RST_PERIOD;
      cc_reg[0]  <= `TCC_ZERO32;
      cc_reg[1]  <= `TCC_ZERO32;
    end else begin
      if (wr_ctrla) begin
        // Mode fields are locked while enabled, unless enabling now
        if (!en && ctrla_w[`TCC_EN_BIT]) begin
          ctrla_reg <= ctrla_w;
        end else if (!en) begin
          ctrla_reg <= ctrla_w;
        end else begin
          ctrla_reg[`TCC_EN_BIT] <= ctrla_w[`TCC_EN_BIT];
        end
      end
      if (wr_ctrlb) begin
        ctrlb_reg <= ctrlb_w[1:0];
      end
      if (wr_evctrl) begin
        if (en) begin
          evctrl_reg <= {evctrl_w[31:2], evctrl_reg[`TCC_EVACT_RNG]};
        end else begin
          evctrl_reg <= evctrl_w;
        end
      end
      if (wr_ctrlc) begin
        ctrlc_reg <= DAT_I[`TCC_INV_RNG];
      end
      if (wr_per & SEL_I[0]) begin
        period_reg <= DAT_I[7:0];
      end
      if (wr_chv0) begin
        cc_reg[0] <= merge(cc_reg[0], DAT_I, SEL_I);
      end
      if (wr_chv1) begin
        cc_reg[1] <= merge(cc_reg[1], DAT_I, SEL_I);
      end
    end
  end

  // ----------------------------------------------------------------
  // Width, top and tick stream
  // ----------------------------------------------------------------
  wire [1:0]  wsel   = ctrla_reg[`TCC_WSEL_RNG];
  wire [1:0]  wmode  = ctrla_reg[`TCC_WMODE_RNG];
  wire [1:0]  evact  = evctrl_reg[`TCC_EVACT_RNG];
  wire        dir    = ctrlb_reg[`TCC_DIR_BIT];
  wire        oneshot = ctrlb_reg[`TCC_ONESHOT_BIT];
  // Even unit carries the full 32 bits of a joined pair
  wire [31:0] maxv   = (wsel == `TCC_WIDTH_EIGHT)     ? `TCC_MAX8 :
                       (wsel == `TCC_WIDTH_THIRTYTWO) ? `TCC_MAX32 : `TCC_MAX16;
  wire        ch0_top = (wmode == `TCC_MATCH_FREQ) | (wmode == `TCC_MATCH_PWM);
  wire [31:0] top    = ch0_top ? (cc_reg[0] & maxv) :
                       (wsel == `TCC_WIDTH_EIGHT) ? {24'h0, period_reg} : maxv;
  wire [31:0] start_val = dir ? top : `TCC_ZERO32;
  wire        active = en & ~follow;
  wire        psc_tick;
  wire        ev_count = (evact == `TCC_EVACT_COUNT);
  // Event counting bypasses the prescaler entirely
  wire        tick = ev_count ? EVENT_I : psc_tick;
  wire        ev_retrig = EVENT_I & (evact == `TCC_EVACT_RETRIGGER);
  wire        ev_start  = EVENT_I & (evact == `TCC_EVACT_START);
  wire        retrig = (cmd == `TCC_CMD_RETRIGGER) | ev_retrig;
  wire        stop   = (cmd == `TCC_CMD_STOP);
  wire        en_rise = en & ~en_q_reg;
  wire        step   = active & run_reg & tick;
  wire        update = step & (dir ? (cnt_reg == `TCC_ZERO32) : (cnt_reg == top));

  tcc_prescaler #(
    .PW     (PW)
  ) u_psc (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .run_i  (active & run_reg & ~ev_count),
    .sel_i  (ctrla_reg[`TCC_PSC_RNG]),
    .tick_o (psc_tick)
  );

  // ----------------------------------------------------------------
  // Counter sequencing
  // ----------------------------------------------------------------
  always @* begin
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    halt_next = halt_reg;
    wclr      = 1'b0;
    tick_step = 1'b0;
    if (!active) begin
      run_next = 1'b0;
    end else if (en_rise) begin
      // Retrigger and start actions wait for their event
      if ((evact != `TCC_EVACT_RETRIGGER) && (evact != `TCC_EVACT_START)) begin
        run_next  = 1'b1;
        halt_next = 1'b0;
      end
      if (!written_reg && dir && (cnt_reg == `TCC_ZERO32)) begin
        cnt_next = top;
      end
    end else if (stop && run_reg) begin
      cnt_next  = start_val;
      run_next  = 1'b0;
      halt_next = 1'b1;
      wclr      = 1'b1;
    end else if (retrig) begin
      if (run_reg) begin
        cnt_next = start_val;
      end else begin
        run_next  = 1'b1;
        halt_next = 1'b0;
      end
    end else if (ev_start && !run_reg) begin
      run_next  = 1'b1;
      halt_next = 1'b0;
    end else if (step) begin
      tick_step = 1'b1;
      if (update) begin
        cnt_next = dir ? top : `TCC_ZERO32;
        if (oneshot) begin
          run_next  = 1'b0;
          halt_next = 1'b1;
          wclr      = 1'b1;
        end
      end else if (dir) begin
        cnt_next = cnt_reg - 32'h0000_0001;
      end else begin
        cnt_next = cnt_reg + 32'h0000_0001;
      end
    end
    // Top above a shrunk width must not leave stale high bits
    cnt_next = cnt_next & maxv;
    if (wr_cnt) begin
      cnt_next = wdat_cnt & maxv;
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cnt_reg     <= `TCC_ZERO32;
      run_reg     <= 1'b0;
      halt_reg    <= 1'b0;
      written_reg <= 1'b0;
      en_q_reg    <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      run_reg  <= run_next;
      halt_reg <= halt_next;
      en_q_reg <= active;
      if (wr_cnt) begin
        written_reg <= 1'b1;
      end else if (en_rise) begin
        written_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  wire [NCH-1:0] match;
  wire [NCH-1:0] wave;
  wire           norm_freq  = (wmode == `TCC_NORMAL_FREQ);
  wire           match_freq = (wmode == `TCC_MATCH_FREQ);

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // Channel 0 in match frequency follows update, not its match
      tcc_channel u_ch (
        .clk_i        (CLK_I),
        .rstn_i       (RSTN_I),
        .tick_i       (tick_step),
        .count_i      (cnt_reg),
        .value_i      (cc_reg[g]),
        .tog_match_i  (norm_freq | (match_freq & (g != 0))),
        .tog_update_i (match_freq & (g == 0)),
        .update_i     (update),
        .clear_i      (wclr),
        .match_o      (match[g]),
        .wave_o       (wave[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags, events and outputs
  // ----------------------------------------------------------------
  wire [1:0] mc_clr  = wr_flag ? DAT_I[`TCC_MC_RNG] : 2'h0;
  wire       ovf_clr = wr_flag & DAT_I[`TCC_OVF_BIT];

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ovf_flag_reg <= 1'b0;
      mc_flag_reg  <= 2'h0;
      EV_OVF_O     <= 1'b0;
      EV_MATCH_O   <= 2'h0;
      WAVE_O       <= 2'h0;
    end else begin
      // A set in the clearing cycle wins
      ovf_flag_reg <= (ovf_flag_reg & ~ovf_clr) | update;
      mc_flag_reg  <= (mc_flag_reg & ~mc_clr) | match;
      EV_OVF_O     <= update & evctrl_reg[`TCC_OVFEO_BIT];
      EV_MATCH_O   <= match & evctrl_reg[`TCC_MCEO_RNG];
      WAVE_O       <= wave ^ ctrlc_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_data = `TCC_ZERO32;
    case (ADR_I)
      `TCC_ADR_CTRLA:   rd_data = ctrla_reg;
      `TCC_ADR_CTRLB:   rd_data = {30'h0, ctrlb_reg};
      `TCC_ADR_EVCTRL:  rd_data = evctrl_reg;
      `TCC_ADR_CTRLC:   rd_data = {30'h0, ctrlc_reg};
      `TCC_ADR_STATUS:  rd_data = {30'h0, follow, halt_reg};
      `TCC_ADR_INTFLAG: rd_data = {29'h0, mc_flag_reg, ovf_flag_reg};
      `TCC_ADR_COUNT:   rd_data = cnt_reg;
      `TCC_ADR_PERIOD:  rd_data = {24'h0, period_reg};
      `TCC_ADR_CHV0:    rd_data = cc_reg[0];
      `TCC_ADR_CHV1:    rd_data = cc_reg[1];
      default:          rd_data = `TCC_ZERO32;
    endcase
  end

endmodule // tcc_core

`default_nettype wire

// >>> pkg/tcc_defines.vh
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCC_ADR_CTRLA   8'h00
`define TCC_ADR_CTRLB   8'h04
`define TCC_ADR_EVCTRL  8'h08
`define TCC_ADR_CTRLC   8'h0c
`define TCC_ADR_STATUS  8'h10
`define TCC_ADR_INTFLAG 8'h14
`define TCC_ADR_COUNT   8'h18
`define TCC_ADR_PERIOD  8'h1c
`define TCC_ADR_CHV0    8'h20
`define TCC_ADR_CHV1    8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCC_EN_BIT      0
`define TCC_WSEL_RNG    3:2
`define TCC_WMODE_RNG   6:5
`define TCC_PSC_RNG     11:8
`define TCC_CTRLA_MASK  32'h0000_0f6d
`define TCC_DIR_BIT     0
`define TCC_ONESHOT_BIT 1
`define TCC_CMD_RNG     6:5
`define TCC_EVACT_RNG   1:0
`define TCC_OVFEO_BIT   8
`define TCC_MCEO_RNG    13:12
`define TCC_EVCTRL_MASK 32'h0000_3103
`define TCC_INV_RNG     1:0
`define TCC_HALT_BIT    0
`define TCC_FOLLOW_BIT  1
`define TCC_OVF_BIT     0
`define TCC_MC_RNG      2:1

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define TCC_WIDTH_SIXTEEN   2'h0
`define TCC_WIDTH_EIGHT     2'h1
`define TCC_WIDTH_THIRTYTWO 2'h2
`define TCC_NORMAL_FREQ     2'h0
`define TCC_MATCH_FREQ      2'h1
`define TCC_NORMAL_PWM      2'h2
`define TCC_MATCH_PWM       2'h3
`define TCC_CMD_RETRIGGER   2'h1
`define TCC_CMD_STOP        2'h2
`define TCC_EVACT_RETRIGGER 2'h1
`define TCC_EVACT_COUNT     2'h2
`define TCC_EVACT_START     2'h3

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TCC_MAX8        32'h0000_00ff
`define TCC_MAX16       32'h0000_ffff
`define TCC_MAX32       32'hffff_ffff
`define TCC_ZERO32      32'h0000_0000
`define TCC_RST_CTRLA   32'h0000_0000
`define TCC_RST_PERIOD  8'hff

`endif

// >>> rtl/tcc_prescaler.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Power-of-two tick divider
// ----------------------------------------------------------------
module tcc_prescaler #(
  parameter PW = 10
) (
  input  wire          clk_i,
  input  wire          rstn_i,
  input  wire          run_i,
  input  wire [3:0]    sel_i,
  output wire          tick_o
);

  reg  [PW-1:0] div_reg;
  wire [PW-1:0] div_mask;

  // Select 0 gives a tick on every clock
  assign div_mask = ~({PW{1'b1}} << sel_i);
  assign tick_o   = run_i & ((div_reg & div_mask) == div_mask);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= {PW{1'b0}};
    end else if (!run_i) begin
      div_reg <= {PW{1'b0}};
    end else begin
      div_reg <= div_reg + {{(PW-1){1'b0}}, 1'b1};
    end
  end

endmodule // tcc_prescaler

`default_nettype wire

// >>> rtl/tcc_channel.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// One compare channel with its waveform toggle
// ----------------------------------------------------------------
module tcc_channel (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        tick_i,
  input  wire [31:0] count_i,
  input  wire [31:0] value_i,
  input  wire        tog_match_i,
  input  wire        tog_update_i,
  input  wire        update_i,
  input  wire        clear_i,
  output wire        match_o,
  output reg         wave_o
);

  // Compared on each tick edge of the count stream
  assign match_o = tick_i & (count_i == value_i);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wave_o <= 1'b0;
    end else if (clear_i) begin
      wave_o <= 1'b0;
    end else if ((tog_match_i & match_o) | (tog_update_i & update_i)) begin
      wave_o <= ~wave_o;
    end
  end

endmodule // tcc_channel

`default_nettype wire

// >>> testbench/tcc_core_chk.sv
`timescale 1ns/100ps
`default_nettype none

module tcc_core_chk #(
  parameter PW = 10
) (
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0]  SEL_I,
  input wire logic        WE_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        EVENT_I,
  input wire logic        FOLLOWER_I,
  input wire logic        EV_OVF_O,
  input wire logic [1:0]  EV_MATCH_O,
  input wire logic [1:0]  WAVE_O
);
  logic       ovfeo_reg;
  logic [1:0] mceo_reg;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Shadow of the event enables; a late wrap may still leave one cycle on
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ovfeo_reg <= 1'b0;
      mceo_reg  <= 2'h0;
    end else if (ACK_O && WE_I && ADR_I == 8'h08 && SEL_I[1]) begin
      ovfeo_reg <= DAT_I[8];
      mceo_reg  <= DAT_I[13:12];
    end
  end

  sequence s_take;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_read(a);
    s_take ##0 (!WE_I && ADR_I == a);
  endsequence

  a_ack_next: assert property (s_take |=> ACK_O)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("ack without request");
  a_dat_hold: assert property (!$rose(ACK_O) |-> $stable(DAT_O))
    else $error("read data moved outside an answer");
  a_rd_hole: assert property (s_take ##0 (!WE_I && ADR_I >= 8'h28) |=> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_cmd_reads0: assert property (s_read(8'h04) |=> DAT_O[6:5] == 2'h0)
    else $error("command field read back");
  a_follow_flag: assert property (s_read(8'h10) |=> DAT_O[1] == $past(FOLLOWER_I))
    else $error("follower status wrong");
  a_reset_quiet: assert property ($rose(RSTN_I) |-> !ACK_O && WAVE_O == 2'h0 && DAT_O == 32'h0)
    else $error("outputs active after reset");
  a_ovf_gated: assert property (EV_OVF_O |-> ovfeo_reg || $past(ovfeo_reg) || $past(ovfeo_reg, 2))
    else $error("overflow event while disabled");
  a_match_gated: assert property ((EV_MATCH_O & ~(mceo_reg | $past(mceo_reg) | $past(mceo_reg, 2))) == 2'h0)
    else $error("match event while disabled");
endmodule  // tcc_core_chk

`default_nettype wire

// >>> testbench/tcc_evnet_model.sv
`timescale 1ns/100ps
`default_nettype none

module tcc_evnet_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] burst_i,
  input  wire logic       go_i,
  input  wire logic [1:0] wave_i,
  output var  logic       ev_o,
  output var  logic [7:0] flips_o
);
  logic [3:0] left_reg;
  logic       wave0_reg;

  // Gap cycle keeps every event a pulse of its own
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_reg  <= 4'h0;
      ev_o      <= 1'b0;
      wave0_reg <= 1'b0;
      flips_o   <= 8'h0;
    end else begin
      wave0_reg <= wave_i[0];
      if (wave_i[0] != wave0_reg) begin
        flips_o <= flips_o + 8'h1;
      end
      if (go_i) begin
        left_reg <= burst_i;
        ev_o     <= 1'b0;
      end else if (left_reg != 4'h0 && !ev_o) begin
        left_reg <= left_reg - 4'h1;
        ev_o     <= 1'b1;
      end else begin
        ev_o <= 1'b0;
      end
    end
  end
endmodule  // tcc_evnet_model

`default_nettype wire

// >>> testbench/tcc_core_tb.sv
`timescale 1ns/100ps
`default_nettype none

module tcc_core_tb;
  logic        clk, rstn, cyc, stb, we, go, follower, ev, ack, ev_ovf, w0;
  logic [7:0]  adr, flips, f0;
  logic [3:0]  sel, burst;
  logic [31:0] dat, rdat, r, t0, t1, ncyc;
  logic [1:0]  ev_match, wave;
  logic [63:0] expq[$];
  logic [63:0] x;
  int          miscompares, num_checks, ovf_n, mat_n, n0;

  tcc_core #(.PW(10)) u_dut (.CLK_I(clk), .RSTN_I(rstn), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel),
    .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(rdat), .ACK_O(ack), .EVENT_I(ev),
    .FOLLOWER_I(follower), .EV_OVF_O(ev_ovf), .EV_MATCH_O(ev_match), .WAVE_O(wave));
  tcc_evnet_model u_net (.clk_i(clk), .rstn_i(rstn), .burst_i(burst), .go_i(go), .wave_i(wave),
    .ev_o(ev), .flips_o(flips));

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("BAD %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------
  // Bus master and event requests
  // ------------------------------
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] m);
    int n;
    n = 0;
    if (!w) expq.push_back({m, e});
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) chk(32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(a, 1'b0, 32'h0, e, m);
  endtask
  task automatic evs(input logic [3:0] k);
    burst <= k;
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2 * k + 4) @(posedge clk);
  endtask
  task automatic wait_ovf(input int k);
    int n;
    n = 0;
    while (ovf_n < k && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) chk(32'h1, 32'h0);
    @(posedge clk);
  endtask

  // ------------------------------
  // Output watcher
  // ------------------------------
  always @(posedge clk) begin
    ncyc <= ncyc + 32'd1;
    if (ev_ovf === 1'b1) begin
      ovf_n++;
      t0 <= t1;
      t1 <= ncyc;
    end
    if (ev_match[0] === 1'b1) mat_n++;
    if (cyc && stb && !we && ack === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else begin
        x = expq.pop_front();
        chk(rdat & x[63:32], x[31:0]);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    {rstn, cyc, stb, we, go, follower} = 6'h0;
    {adr, sel, burst, dat, ncyc, t0, t1} = '0;
    r = $urandom(32'h2620);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'hff, 32'hff);
    rd(8'h40, 32'h0, 32'hffffffff);
    // 8-bit, period 16 clocks, up then down
    wr(8'h08, 32'h100);
    wr(8'h1c, 32'h0f);
    wr(8'h00, 32'h5);
    wait_ovf(ovf_n + 2);
    chk(t1 - t0, 32'd16);
    rd(8'h14, 32'h1, 32'h1);
    wr(8'h04, 32'h40);
    rd(8'h18, 32'h0, 32'hff);
    rd(8'h10, 32'h1, 32'h1);
    chk({30'h0, wave}, 32'h0);
    wr(8'h04, 32'h21);
    wait_ovf(ovf_n + 2);
    chk(t1 - t0, 32'd16);
    wr(8'h04, 32'h41);
    rd(8'h18, 32'h0f, 32'hff);
    rd(8'h04, 32'h1, 32'h61);
    wr(8'h14, 32'h1);
    rd(8'h14, 32'h0, 32'h1);
    follower <= 1'b1;
    wr(8'h1c, 32'h33);
    rd(8'h1c, 32'h0f, 32'hff);
    rd(8'h10, 32'h2, 32'h2);
    follower <= 1'b0;
    // Counting events
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h18, 32'h5);
    wr(8'h00, 32'h5);
    repeat (20) @(posedge clk);
    rd(8'h18, 32'h5, 32'hff);
    evs(4'd3);
    rd(8'h18, 32'h8, 32'hff);
    wr(8'h04, 32'h20);
    rd(8'h18, 32'h0, 32'hff);
    wr(8'h04, 32'h1);
    evs(4'd2);
    rd(8'h18, 32'h0e, 32'hff);
    // Normal frequency toggle and invert
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h1002);
    wr(8'h04, 32'h0);
    wr(8'h20, 32'h3);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h7);
    wr(8'h00, 32'h5);
    f0 = flips;
    n0 = mat_n;
    evs(4'd4);
    chk({24'h0, flips - f0}, 32'h1);
    rd(8'h14, 32'h2, 32'h2);
    chk(mat_n - n0, 32'h1);
    w0 = wave[0];
    wr(8'h0c, 32'h1);
    // Output register takes the new invert one edge after the write
    @(posedge clk);
    chk({31'h0, wave[0]}, {31'h0, ~w0});
    wr(8'h0c, 32'h0);
    // Retrigger and start actions with one-shot
    for (int a = 1; a <= 3; a += 2) begin
      wr(8'h00, 32'h4);
      wr(8'h08, 32'h100 | a);
      wr(8'h04, 32'h2);
      wr(8'h18, 32'h0);
      wr(8'h00, 32'h5);
      n0 = ovf_n;
      repeat (40) @(posedge clk);
      chk(ovf_n - n0, 32'd0);
      evs(4'd1);
      repeat (40) @(posedge clk);
      chk(ovf_n - n0, 32'd1);
      rd(8'h10, 32'h1, 32'h1);
      chk({30'h0, wave}, 32'h0);
      wr(8'h04, 32'h22);
      repeat (40) @(posedge clk);
      chk(ovf_n - n0, 32'd2);
    end
    // Match frequency, channel 0 sets the period
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h100);
    wr(8'h04, 32'h0);
    wr(8'h20, 32'h4);
    wr(8'h18, 32'h0);
    wr(8'h00, 32'h25);
    f0 = flips;
    wait_ovf(ovf_n + 3);
    chk(t1 - t0, 32'd5);
    chk({31'h0, (flips - f0) > 8'd1}, 32'h1);
    // Stop at zero, then enable counting down: starts from top
    wr(8'h04, 32'h41);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h1);
    rd(8'h18, 32'hffff, 32'hffff);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wr(8'h18, r);
      rd(8'h18, r & 32'hffff, 32'hffff);
    end
    // Joined 32-bit width keeps every bit of a count write
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h9);
    r = $urandom;
    wr(8'h18, r);
    rd(8'h18, r, 32'hffffffff);
    report_and_stop();
  end
endmodule  // tcc_core_tb

bind tcc_core tcc_core_chk #(.PW(PW)) u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADR_I(ADR_I),
  .DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .EVENT_I(EVENT_I), .FOLLOWER_I(FOLLOWER_I), .EV_OVF_O(EV_OVF_O),
  .EV_MATCH_O(EV_MATCH_O), .WAVE_O(WAVE_O));

`default_nettype wire
